// file: verilog/pmf_slave.sv
// management-port slave framing: start, address, command, data, stop
//
// How it works
// - start or repeated start opens a transfer
// - direction one reads, zero writes
// - slave acks address, command, write bytes low
// - one to four read bytes, up to six write bytes per command
// - unsigned voltage mantissa scaled by two^-14
// - signed voltage mantissa scaled by two^-15
// - format byte: mode 000, exponent -14/-15
// - temperature linear, voltage mantissa formats
// - temperature: exponent 15:11, mantissa 10:0
// - longest read 32 bits, sent bytewise
// - read: repeated start, low byte first
// - zero-byte write: command alone is action
`timescale 1ns/1ns
module pmf_slave
	import pmf_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = PMF_DEF_ADDR, // arbitrary value
	parameter bit SIGNED_FMT = 1'b0 // voltage format selection
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic scl_in, // serial clock, sampled synchronously
	input wire logic sda_in, // serial data in
	output logic sda_out, // always low when driving
	output logic sda_oe, // high while pulling data low
	output logic [7:0] cmd_code, // last command received
	output logic cmd_strobe, // pulse: command byte (or bare command)
	output logic [7:0] wr_data, // write data byte
	output logic wr_strobe, // pulse per accepted write byte
	output logic [1:0] wr_index, // byte index of wr_data modulo four (0 = low)
	output logic rd_req, // pulse: read started for cmd_code
	input wire logic [31:0] rd_word, // read data, low byte sent first
	input wire logic [2:0] rd_len, // bytes the command returns (1..4)
	output logic busy // transfer open
);
	// ==========================================================
	// state
	typedef struct packed {
		pmf_state_t st;
		logic scl_p; // previous scl
		logic sda_p; // previous sda
		logic [7:0] sh; // shift register
		logic [3:0] bits; // bit counter
		logic rd; // current direction
		logic first; // next write byte is command
		logic [2:0] cnt; // data byte count
		logic [7:0] cmd;
		logic cmd_stb;
		logic [7:0] wd;
		logic wstb;
		logic [1:0] widx;
		logic rreq;
		logic oe;
		logic busy;
	} pmf_reg_t;
	pmf_reg_t q, d;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic [7:0] rd_first, rd_next; // byte to send first / next

	// output format byte content: mode zero, then the exponent,
	// -15 for the signed format, -14 for the unsigned
	function automatic logic [7:0] fmt_byte(input bit sgn);
		fmt_byte = {PMF_MODE_LINEAR, sgn ? PMF_EXP_SIGNED : PMF_EXP_UNSIGNED};
	endfunction

	// byte of the read word: low byte first
	function automatic logic [7:0] rd_byte(input logic [2:0] i,
		input logic [31:0] w, input logic [7:0] c);
		if (c == PMF_CMD_OUT_FMT)
			rd_byte = fmt_byte(SIGNED_FMT);
		else
			// linear words go out unchanged
			rd_byte = w[{i[1:0], 3'b000} +: 8];
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		d.scl_p = scl_in;
		d.sda_p = sda_in;
		d.cmd_stb = 1'b0;
		d.wstb = 1'b0;
		d.rreq = 1'b0;
		scl_rise = scl_in & ~q.scl_p;
		scl_fall = ~scl_in & q.scl_p;
		start_c = scl_in & q.scl_p & q.sda_p & ~sda_in;
		stop_c = scl_in & q.scl_p & ~q.sda_p & sda_in;
		// read bytes held apart: a function result cannot be bit-selected
		rd_first = rd_byte(3'd0, rd_word, q.cmd);
		rd_next = rd_byte(q.cnt, rd_word, q.cmd);
		if (start_c) begin
			// repeated start keeps the command
			d.st = PMF_ADDR;
			d.bits = '0;
			d.oe = 1'b0;
			d.busy = 1'b1;
		end else if (stop_c) begin
			// bare command write acts at stop
			if (q.st != PMF_IDLE && !q.rd && !q.first && q.cnt == '0)
				d.cmd_stb = 1'b1;
			d.st = PMF_IDLE;
			d.oe = 1'b0;
			d.busy = 1'b0;
		end else begin
			unique case (q.st)
			PMF_IDLE: begin
				d.oe = 1'b0;
			end
			PMF_ADDR, PMF_WBYTE: begin
				// shift on rising edge
				if (scl_rise) begin
					d.sh = {q.sh[6:0], sda_in};
					d.bits = q.bits + 4'd1;
				end
				if (scl_fall && q.bits == 4'd8) begin
					d.bits = '0;
					if (q.st == PMF_ADDR) begin
						if (q.sh[7:1] == SLAVE_ADDR) begin
							d.rd = (q.sh[0] == PMF_DIR_READ);
							d.first = (q.sh[0] != PMF_DIR_READ);
							d.cnt = '0;
							d.oe = 1'b1;
							d.st = PMF_ADDR_ACK;
						end else begin
							d.st = PMF_IDLE; // not ours
						end
					end else if (q.first) begin
						d.cmd = q.sh;
						d.first = 1'b0;
						d.oe = 1'b1;
						d.st = PMF_WACK;
					end else if (q.cnt < 3'(PMF_MAX_WR)) begin
						// 48-bit write cap
						d.wd = q.sh;
						d.wstb = 1'b1;
						d.widx = q.cnt[1:0];
						d.cnt = q.cnt + 3'd1;
						d.oe = 1'b1;
						d.st = PMF_WACK;
					end else begin
						d.st = PMF_WACK; // overlong: nack
					end
				end
			end
			PMF_ADDR_ACK: begin
				// release after ack clock, or drive first read bit
				if (scl_fall) begin
					if (q.rd) begin
						d.rreq = 1'b1;
						d.sh = rd_first;
						d.oe = ~rd_first[7];
						d.bits = 4'd1;
						d.cnt = 3'd1;
						d.st = PMF_RBYTE;
					end else begin
						d.oe = 1'b0;
						d.st = PMF_WBYTE;
					end
				end
			end
			PMF_WACK: begin
				if (scl_fall) begin
					if (q.oe && q.cnt == '0)
						d.cmd_stb = 1'b0;
					d.oe = 1'b0;
					d.st = PMF_WBYTE;
				end
			end
			PMF_RBYTE: begin
				// shift out msb first on falling edges
				if (scl_fall) begin
					if (q.bits == 4'd8) begin
						d.oe = 1'b0;
						d.st = PMF_RACK;
					end else begin
						d.oe = ~q.sh[6];
						d.sh = {q.sh[6:0], 1'b0};
						d.bits = q.bits + 4'd1;
					end
				end
			end
			PMF_RACK: begin
				// host ack continues, nack releases
				if (scl_rise && sda_in != PMF_ACK)
					d.st = PMF_IDLE;
				else if (scl_fall) begin
					if (q.cnt < rd_len && q.cnt < 3'(PMF_MAX_RD)) begin
						d.sh = rd_next;
						d.oe = ~rd_next[7];
						d.bits = 4'd1;
						d.cnt = q.cnt + 3'd1;
						d.st = PMF_RBYTE;
					end else begin
						d.st = PMF_IDLE; // nothing left: release
					end
				end
			end
			endcase
		end
		// command known once acked
		if (q.st == PMF_WBYTE && d.st == PMF_WACK && q.first)
			d.cmd_stb = 1'b1;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			q <= '0;
			q.scl_p <= 1'b1;
			q.sda_p <= 1'b1;
			q.st <= PMF_IDLE;
		end else begin
			q <= d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = q.oe;
	assign cmd_code = q.cmd;
	assign cmd_strobe = q.cmd_stb;
	assign wr_data = q.wd;
	assign wr_strobe = q.wstb;
	assign wr_index = q.widx;
	assign rd_req = q.rreq;
	assign busy = q.busy;

	// ==========================================================
	// checks
	// stop: data rises while the clock stays high on two samples
	sequence s_stop;
		scl_in && $past(scl_in) && !$past(sda_in) && sda_in;
	endsequence
	// first three bits of a format byte on the wire: the mode field
	sequence s_fmt_mode;
		q.st == PMF_RBYTE && q.cmd == PMF_CMD_OUT_FMT && q.bits <= 4'd3;
	endsequence
	AST_STOP_RELEASE: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		s_stop |=> !sda_oe && !busy)
		else $error("stop did not release the link");
	AST_START_BUSY: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		start_c |=> busy && !sda_oe)
		else $error("start not taken");
	AST_WSTB_ACK: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		wr_strobe |-> sda_oe)
		else $error("write byte not acknowledged");
	// a strobed byte must lie inside the longest write
	AST_WIDX: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		wr_strobe |-> q.cnt != 3'd0 && q.cnt <= 3'(PMF_MAX_WR))
		else $error("write byte beyond the longest write");
	// mode bits are zero, so the slave pulls low for all three
	AST_FMT: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		s_fmt_mode |-> sda_oe)
		else $error("format mode bits not zero");
	AST_NACK_REL: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		q.st == PMF_RACK && scl_rise && sda_in |=> !sda_oe [*2])
		else $error("data driven after nack");
	AST_RREQ: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		rd_req |-> q.rd && q.cnt == 3'd1)
		else $error("read request outside read");
endmodule

// file: common/pmf_pkg.sv
// shared constants for the management-port slave framing block
package pmf_pkg;
	// ==========================================================
	// link framing
	localparam int PMF_ADDR_W = 7; // slave address width
	localparam int PMF_CMD_W = 8; // command code width
	localparam int PMF_MAX_RD = 4; // longest read in bytes
	localparam int PMF_MAX_WR = 6; // data bytes after command (48 bits)
	localparam logic [6:0] PMF_DEF_ADDR = 7'h2A; // arbitrary default address
	localparam logic PMF_DIR_READ = 1'b1; // direction bit for read
	localparam logic PMF_ACK = 1'b0; // acknowledge level
	// ==========================================================
	// command codes and data formats
	localparam logic [7:0] PMF_CMD_OUT_FMT = 8'h20; // output format byte
	localparam logic [2:0] PMF_MODE_LINEAR = 3'h0; // upper mode bits
	localparam logic [4:0] PMF_EXP_UNSIGNED = 5'h12; // -14
	localparam logic [4:0] PMF_EXP_SIGNED = 5'h11; // -15
	localparam int PMF_L11_EXP_LSB = 11; // exponent starts at bit 11
	localparam int PMF_L11_MAN_W = 11; // mantissa width
	typedef enum logic [2:0] {
		PMF_IDLE, PMF_ADDR, PMF_ADDR_ACK, PMF_WBYTE, PMF_WACK, PMF_RBYTE,
		PMF_RACK
	} pmf_state_t;
endpackage

// file: testbench/pmf_host.sv
// host model of the serial management link (bus master)
`timescale 1ns/1ns
module pmf_host (
	input wire logic clk_sys,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic drv; // host level, 1 = released
	// open drain wire, pulled high when nobody pulls
	assign sda = drv & ~sda_oe;
	initial begin
		scl = 1'b1;
		drv = 1'b1;
	end
	// =============================================
	// bit level
	// one bit: data moves a cycle after the clock falls, never while high
	task automatic bit_io(input logic b, output logic r);
		@(negedge clk_sys);
		drv = b;
		repeat (3) @(negedge clk_sys);
		scl = 1'b1;
		repeat (2) @(negedge clk_sys);
		r = sda;
		repeat (2) @(negedge clk_sys);
		scl = 1'b0;
	endtask
	// byte msb first, then ninth bit; d = FF releases for reading
	task automatic xfer(input logic [7:0] d, input logic a_in,
		output logic [7:0] q, output logic a_out);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(a_in, a_out);
	endtask
	// start or repeated start: data falls while clock high
	task automatic start();
		@(negedge clk_sys);
		drv = 1'b1;
		repeat (2) @(negedge clk_sys);
		scl = 1'b1;
		repeat (4) @(negedge clk_sys);
		drv = 1'b0;
		repeat (4) @(negedge clk_sys);
		scl = 1'b0;
	endtask
	// stop: data rises while clock high
	task automatic stop();
		@(negedge clk_sys);
		drv = 1'b0;
		repeat (2) @(negedge clk_sys);
		scl = 1'b1;
		repeat (4) @(negedge clk_sys);
		drv = 1'b1;
		repeat (4) @(negedge clk_sys);
	endtask
endmodule

// file: testbench/pmbus_monitor_slave_framing_bench.sv
// self-checking bench for the management-port slave framing
`timescale 1ns/1ns
module pmbus_monitor_slave_framing_bench;
	import pmf_pkg::*;
	localparam logic [6:0] SGN_ADDR = 7'h3C; // second slave's address
	typedef struct {
		logic [7:0] cmd;
		logic [2:0] len;
		logic [31:0] word;
		logic [31:0] exp;
	} pmf_row_t;
	logic clk_sys, rstn, scl, sda, sda_out, sda_oe, cmd_strobe, wr_strobe;
	logic rd_req, busy, ak, sda_oe_sgn;
	logic [7:0] cmd_code, wr_data, q;
	logic [1:0] wr_index;
	logic [31:0] rd_word;
	logic [2:0] rd_len;
	int error_cnt = 0, checks_done = 0, cyc = 0, n_cmd = 0, n_wr = 0, n0;
	int n_rd = 0; // read requests seen
	pmf_row_t rows [4]; // read cases: command, length, source, stream
	pmf_slave i_pmf_slave (.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.cmd_code(cmd_code), .cmd_strobe(cmd_strobe), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .wr_index(wr_index), .rd_req(rd_req),
		.rd_word(rd_word), .rd_len(rd_len), .busy(busy));
	// second slave on the same wire, signed voltage format
	pmf_slave #(.SLAVE_ADDR(SGN_ADDR), .SIGNED_FMT(1'b1)) i_pmf_slave_sgn (
		.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe_sgn), .cmd_code(), .cmd_strobe(),
		.wr_data(), .wr_strobe(), .wr_index(), .rd_req(), .rd_word(rd_word),
		.rd_len(rd_len), .busy());
	// either slave may pull the shared data wire low
	pmf_host i_pmf_host (.clk_sys(clk_sys), .sda_oe(sda_oe | sda_oe_sgn),
		.scl(scl), .sda(sda));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// =============================================
	// strobe counters and watchdog; ceiling well above the run's length
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cmd_strobe === 1'b1) n_cmd <= n_cmd + 1;
		if (wr_strobe === 1'b1) n_wr <= n_wr + 1;
		if (rd_req === 1'b1) n_rd <= n_rd + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// start, address with direction, slave answer in the ninth bit
	task automatic adr(input logic [6:0] a, input logic dir, input logic e);
		i_pmf_host.start();
		i_pmf_host.xfer({a, dir}, 1'b1, q, ak);
		chk(ak === e, "address ack");
	endtask
	task automatic wb(input logic [7:0] d, input logic e);
		i_pmf_host.xfer(d, 1'b1, q, ak);
		chk(ak === e, "byte ack");
	endtask
	// =============================================
	// main sequence
	initial begin
		rstn = 1'b0;
		rd_word = '0;
		rd_len = 3'h1;
		rows[0] = '{8'h8D, 3'h2, 32'h0000EA81, 32'h0000EA81};
		rows[1] = '{8'hD1, 3'h4, 32'h12345678, 32'h12345678};
		rows[2] = '{8'h99, 3'h3, 32'h00ABCDEF, 32'h00ABCDEF};
		rows[3] = '{PMF_CMD_OUT_FMT, 3'h1, 32'h00000077,
			{24'h0, PMF_MODE_LINEAR, PMF_EXP_UNSIGNED}};
		repeat (12) @(negedge clk_sys);
		rstn = 1'b1;
		chk(busy === 1'b0 && sda_oe === 1'b0 && cmd_code === 8'h00, "reset");
		chk(sda_out === 1'b0, "data level");
		repeat (4) @(negedge clk_sys);
		// write command, repeated start, read bytes low first
		foreach (rows[r]) begin
			rd_word = rows[r].word;
			rd_len = rows[r].len;
			adr(PMF_DEF_ADDR, 1'b0, PMF_ACK);
			wb(rows[r].cmd, PMF_ACK);
			chk(cmd_code === rows[r].cmd, "command kept");
			adr(PMF_DEF_ADDR, PMF_DIR_READ, PMF_ACK);
			for (int k = 0; k < rows[r].len; k++) begin
				i_pmf_host.xfer(8'hFF, k == rows[r].len - 1, q, ak);
				chk(q === rows[r].exp[8*k +: 8], "read byte");
			end
			i_pmf_host.stop();
			chk(busy === 1'b0 && sda_oe === 1'b0, "released");
			chk(n_rd == r + 1, "read request");
		end
		// foreign address is left unanswered
		adr(PMF_DEF_ADDR ^ 7'h01, 1'b0, 1'b1);
		i_pmf_host.stop();
		// longest write, then one byte too many
		n0 = n_wr;
		adr(PMF_DEF_ADDR, 1'b0, PMF_ACK);
		wb(8'hD1, PMF_ACK);
		for (int k = 0; k < 7; k++) begin
			wb(8'hA0 | 8'(k), k < PMF_MAX_WR ? 1'b0 : 1'b1);
			// low byte first: the index counts up from zero
			if (k < 4) begin
				chk(wr_index === 2'(k), "write index");
			end
		end
		i_pmf_host.stop();
		chk(n_wr - n0 == PMF_MAX_WR && wr_data === 8'hA5, "write bytes");
		// bare command: strobe at the command and again at stop
		n0 = n_cmd;
		adr(PMF_DEF_ADDR, 1'b0, PMF_ACK);
		wb(8'hD8, PMF_ACK);
		i_pmf_host.stop();
		chk(n_cmd - n0 == 2 && cmd_code === 8'hD8, "bare command");
		// second slave in the signed format reports exponent -15
		adr(SGN_ADDR, 1'b0, PMF_ACK);
		wb(PMF_CMD_OUT_FMT, PMF_ACK);
		adr(SGN_ADDR, PMF_DIR_READ, PMF_ACK);
		i_pmf_host.xfer(8'hFF, 1'b1, q, ak);
		chk(q === {PMF_MODE_LINEAR, PMF_EXP_SIGNED}, "signed format");
		i_pmf_host.stop();
		// reset in mid-transfer: outputs back to zero, then a fresh start
		adr(PMF_DEF_ADDR, 1'b0, PMF_ACK);
		wb(8'h8D, PMF_ACK);
		rstn = 1'b0;
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		chk(busy === 1'b0 && cmd_code === 8'h00, "mid-run reset");
		i_pmf_host.stop();
		adr(PMF_DEF_ADDR, 1'b0, PMF_ACK);
		i_pmf_host.stop();
		end_sim();
	end
endmodule
